//--- rtl/uhr_pkg.sv
package uhr_pkg;
   localparam int NPORT      = 4;
   localparam int FIFO_W     = 8;
   localparam int FIFO_D     = 16;
   localparam int CLK_MHZ    = 200;
   localparam int CTRL_KHZ   = 12000;
   localparam int CTRL_DIV   = CLK_MHZ * 1000 / CTRL_KHZ;
   localparam int SUSP_MS    = 3;
   localparam int SUSP_CYC   = SUSP_MS * CLK_MHZ * 1000;
   localparam int RESUME_MS  = 1;
   localparam int RESUME_CYC = RESUME_MS * CLK_MHZ * 1000;
   localparam int UFRAME_NS  = 125000;
   localparam int UFRAME_CYC = UFRAME_NS * CLK_MHZ / 1000;
   localparam int STUFF_RUN  = 6;
   localparam int EE_LEN     = 8;
   localparam logic [2:0] EE_LAST = 3'h7;
   localparam logic [7:0] EE_SIG  = 8'hA5;
   // Arbitrary identity values
   localparam logic [15:0] DEF_VID = 16'h1234;
   localparam logic [15:0] DEF_PID = 16'h5678;
   localparam logic [1:0] SPD_LS = 2'h0;
   localparam logic [1:0] SPD_FS = 2'h1;
   localparam logic [1:0] SPD_HS = 2'h2;
   localparam logic [3:0] PID_OUT   = 4'h1;
   localparam logic [3:0] PID_IN    = 4'h9;
   localparam logic [3:0] PID_SOF   = 4'h5;
   localparam logic [3:0] PID_SETUP = 4'hD;

   typedef struct packed {
      logic [7:0] pid;
      logic [6:0] addr;
      logic [3:0] endp;
      logic [4:0] crc;
   } uhr_token_s;

   typedef struct packed {
      logic [15:0] vid;
      logic [15:0] pid;
   } uhr_ids_s;

   typedef enum logic [1:0] {
      EE_IDLE  = 2'b00,
      EE_READ  = 2'b01,
      EE_CHECK = 2'b10,
      EE_DONE  = 2'b11
   } uhr_ee_e;

   function automatic logic [4:0] uhr_crc5(input logic [10:0] d);
      logic [4:0] c;
      logic       fb;
      c = 5'h1F;
      for (int i = 0; i < 11; i++) begin
         fb = d[i] ^ c[4];
         c  = {c[3:0], 1'b0} ^ (fb ? 5'h05 : 5'h00);
      end
      return ~{c[0], c[1], c[2], c[3], c[4]};
   endfunction : uhr_crc5

   // Translator only when host is high speed and device is not
   function automatic logic uhr_route_tt(input logic hostHs, input logic [1:0] spd);
      return hostHs && (spd != SPD_HS);
   endfunction : uhr_route_tt
endpackage : uhr_pkg

//--- rtl/uhr_hub_core.sv
`timescale 1ns/1ps
`default_nettype none

module uhr_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         inValid,
   output logic              inReady,
   input  wire logic [W-1:0] inData,
   output logic              outValid,
   input  wire logic         outReady,
   output logic [W-1:0]      outData
);
   localparam int AW = $clog2(D);
   logic [W-1:0]      mem [D];
   logic [AW-1:0]     wrPtr_reg;
   logic [AW-1:0]     rdPtr_reg;
   logic [AW:0]       count_reg;
   logic              push;
   logic              pop;

   assign inReady  = count_reg != (AW+1)'(D);
   assign outValid = count_reg != '0;
   assign outData  = mem[rdPtr_reg];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_reg] <= inData;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         wrPtr_reg <= wrPtr_reg + AW'(push);
         rdPtr_reg <= rdPtr_reg + AW'(pop);
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : uhr_fifo

module uhr_hub_core
   import uhr_pkg::*;
#(
   parameter int SUSP_CYCLES   = uhr_pkg::SUSP_CYC,
   parameter int RESUME_CYCLES = uhr_pkg::RESUME_CYC,
   parameter int UFRAME_CYCLES = uhr_pkg::UFRAME_CYC
) (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        eePresent,
   input  wire logic [7:0]                  eeData,
   input  wire logic                        eeAck,
   output logic                             eeReq,
   output logic [2:0]                       eeAddr,
   output uhr_pkg::uhr_ids_s                ids,
   output logic                             idsFromEe,
   output logic                             pullupEn,
   input  wire logic                        busReset,
   input  wire logic                        hostHs,
   input  wire logic                        setAddr,
   input  wire logic [6:0]                  newAddr,
   input  wire logic                        setCfg,
   input  wire logic [7:0]                  newCfg,
   output logic [6:0]                       devAddr,
   output logic [7:0]                       cfgValue,
   output logic                             configured,
   input  wire logic                        tokenValid,
   input  wire uhr_pkg::uhr_token_s         token,
   output logic                             tokenHit,
   output logic [3:0]                       tokenKind,
   output logic                             uframeTick,
   input  wire logic                        rxBit,
   input  wire logic                        rxBitValid,
   input  wire logic                        rxEop,
   input  wire logic [1:0]                  txTarget,
   output logic                             rxBitReady,
   output logic                             stuffErr,
   output logic [7:0]                       dnData,
   output logic                             dnValid,
   input  wire logic                        dnReady,
   output logic [1:0]                       dnPort,
   input  wire logic                        busIdle,
   output logic                             suspended,
   output logic                             resumeOut,
   input  wire logic [3:0]                  portConnect,
   input  wire logic [3:0]                  portOvcDet,
   input  wire logic [3:0]                  portPowerSet,
   input  wire logic [3:0]                  portResetDone,
   input  wire logic [3:0][1:0]             portSpeed,
   input  wire logic [3:0]                  portWake,
   output logic [3:0]                       portPower,
   output logic [3:0]                       portSe0,
   output logic [3:0]                       portEnabled,
   output logic [3:0]                       portRouteTt,
   output logic [3:0][1:0]                  portSpeedEff,
   output logic [3:0]                       portLedGreen,
   output logic [3:0]                       portLedAmber,
   output logic [3:0]                       portChange,
   input  wire logic                        splitValid,
   input  wire logic [1:0]                  splitPort,
   input  wire logic                        ttDone,
   output logic                             ttStart,
   output logic [1:0]                       ttPort,
   output logic                             ttBusy
);
   import uhr_pkg::*;

   uhr_ee_e     eeState_reg;
   logic [4:0]  ctrlDiv_reg;
   logic        ctrlTick;
   logic [7:0]  eeBuf [EE_LEN];
   logic [7:0]  eeSum_reg;
   logic [7:0]  cfgNext;
   logic        rxActive_reg;
   logic [2:0]  ones_reg;
   logic [2:0]  bitCnt_reg;
   logic [7:0]  shift_reg;
   logic        byteFull_reg;
   logic        bitTake;
   logic        fifoInReady;
   logic        fifoOutValid;
   logic        fifoPop;
   logic [7:0]  fifoOutData;
   logic [19:0] idleCnt_reg;
   logic [19:0] resCnt_reg;
   logic [19:0] uframeCnt_reg;
   logic [3:0]  connPrev_reg;
   logic [3:0]  ovcPrev_reg;
   logic        tokCrcOk;

   // Controller pace: one step every 16 clocks, a 12.5 MHz tick
   assign ctrlTick = ctrlDiv_reg == 5'(CTRL_DIV - 1);

   always_ff @(posedge clk) begin
      if (rst || ctrlTick) begin
         ctrlDiv_reg <= '0;
      end else begin
         ctrlDiv_reg <= ctrlDiv_reg + 5'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         eeState_reg <= EE_IDLE;
         eeReq       <= 1'b0;
         eeAddr      <= '0;
         eeSum_reg   <= '0;
         ids         <= '{vid: DEF_VID, pid: DEF_PID};
         idsFromEe   <= 1'b0;
         pullupEn    <= 1'b0;
      end else begin
         case (eeState_reg)
            EE_IDLE: if (ctrlTick) begin
               eeState_reg <= eePresent ? EE_READ : EE_DONE;
            end
            EE_READ: begin
               if (eeReq && eeAck) begin
                  eeReq                <= 1'b0;
                  eeBuf[eeAddr]        <= eeData;
                  eeAddr               <= eeAddr + 3'h1;
                  if (eeAddr != EE_LAST) begin
                     eeSum_reg <= eeSum_reg + eeData;
                  end else begin
                     eeState_reg <= EE_CHECK;
                  end
               end else if (!eeReq && ctrlTick) begin
                  eeReq <= 1'b1;
               end
            end
            EE_CHECK: begin
               // Only a good image replaces the defaults
               if (eeSum_reg == eeBuf[EE_LAST] && eeBuf[0] == EE_SIG) begin
                  ids       <= '{vid: {eeBuf[2], eeBuf[1]}, pid: {eeBuf[4], eeBuf[3]}};
                  idsFromEe <= 1'b1;
               end
               eeState_reg <= EE_DONE;
            end
            EE_DONE: pullupEn <= 1'b1;
            default: eeState_reg <= EE_IDLE;
         endcase
      end
   end

   // Configuration seen one edge ahead so SE0 and power follow at once
   always_comb begin
      cfgNext = cfgValue;
      if (busReset) begin
         cfgNext = 8'h00;
      end else if (setCfg && pullupEn) begin
         cfgNext = newCfg;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         devAddr    <= '0;
         cfgValue   <= '0;
         configured <= 1'b0;
         portSe0    <= 4'hF;
      end else begin
         if (busReset) begin
            devAddr <= '0;
         end else if (setAddr && pullupEn) begin
            devAddr <= newAddr;
         end
         cfgValue   <= cfgNext;
         configured <= cfgNext != 8'h00;
         portSe0    <= (cfgNext == 8'h00) ? 4'hF : 4'h0;
      end
   end

   assign tokCrcOk = token.crc == uhr_crc5({token.endp, token.addr});

   always_ff @(posedge clk) begin
      if (rst) begin
         tokenHit  <= 1'b0;
         tokenKind <= '0;
      end else begin
         tokenHit  <= tokenValid && tokCrcOk && token.pid[3:0] == ~token.pid[7:4]
                      && token.addr == devAddr && token.pid[3:0] != PID_SOF;
         tokenKind <= tokenValid ? token.pid[3:0] : tokenKind;
      end
   end

   // Free-running fallback keeps ticking if an SOF is lost
   always_ff @(posedge clk) begin
      if (rst) begin
         uframeCnt_reg <= '0;
         uframeTick    <= 1'b0;
      end else if (tokenValid && tokCrcOk && token.pid[3:0] == PID_SOF) begin
         uframeCnt_reg <= '0;
         uframeTick    <= 1'b1;
      end else begin
         uframeTick    <= uframeCnt_reg == 20'(UFRAME_CYCLES - 1);
         uframeCnt_reg <= (uframeCnt_reg == 20'(UFRAME_CYCLES - 1)) ? '0
                          : uframeCnt_reg + 20'h1;
      end
   end

   assign bitTake = rxBitValid && rxBitReady;

   always_ff @(posedge clk) begin
      if (rst) begin
         rxActive_reg <= 1'b0;
         dnPort       <= '0;
      end else if (rxEop) begin
         rxActive_reg <= 1'b0;
      end else if (bitTake) begin
         rxActive_reg <= 1'b1;
         if (!rxActive_reg) begin
            dnPort <= txTarget;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ones_reg     <= '0;
         bitCnt_reg   <= '0;
         shift_reg    <= '0;
         byteFull_reg <= 1'b0;
         stuffErr     <= 1'b0;
         rxBitReady   <= 1'b0;
      end else begin
         stuffErr <= bitTake && ones_reg == 3'(STUFF_RUN) && rxBit;
         if (rxEop) begin
            ones_reg   <= '0;
            bitCnt_reg <= '0;
         end else if (bitTake) begin
            ones_reg <= rxBit ? ones_reg + 3'h1 : 3'h0;
            // Stuffed zero after six ones is dropped
            if (ones_reg != 3'(STUFF_RUN)) begin
               shift_reg  <= {rxBit, shift_reg[7:1]};
               bitCnt_reg <= bitCnt_reg + 3'h1;
            end
         end
         if (bitTake && ones_reg != 3'(STUFF_RUN) && bitCnt_reg == 3'h7) begin
            byteFull_reg <= 1'b1;
            rxBitReady   <= 1'b0;
         end else if (byteFull_reg && fifoInReady) begin
            byteFull_reg <= 1'b0;
            rxBitReady   <= 1'b1;
         end else begin
            rxBitReady   <= !byteFull_reg;
         end
      end
   end

   uhr_fifo #(
      .W (FIFO_W),
      .D (FIFO_D)
   ) u_fifo (
      .clk      (clk),
      .rst      (rst),
      .inValid  (byteFull_reg),
      .inReady  (fifoInReady),
      .inData   (shift_reg),
      .outValid (fifoOutValid),
      .outReady (fifoPop),
      .outData  (fifoOutData)
   );

   assign fifoPop = fifoOutValid && (!dnValid || dnReady);

   always_ff @(posedge clk) begin
      if (rst) begin
         dnValid <= 1'b0;
         dnData  <= '0;
      end else if (!dnValid || dnReady) begin
         dnValid <= fifoOutValid;
         dnData  <= fifoOutValid ? fifoOutData : dnData;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         idleCnt_reg <= '0;
         resCnt_reg  <= '0;
         suspended   <= 1'b0;
         resumeOut   <= 1'b0;
      end else begin
         if (!busIdle || !pullupEn) begin
            idleCnt_reg <= '0;
            suspended   <= 1'b0;
         end else if (idleCnt_reg == 20'(SUSP_CYCLES - 1)) begin
            suspended   <= 1'b1;
         end else begin
            idleCnt_reg <= idleCnt_reg + 20'h1;
         end
         if (resumeOut) begin
            resCnt_reg <= resCnt_reg + 20'h1;
            resumeOut  <= resCnt_reg != 20'(RESUME_CYCLES - 1);
         end else if (suspended && |portWake) begin
            resumeOut  <= 1'b1;
            resCnt_reg <= '0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         portPower    <= '0;
         portEnabled  <= '0;
         portRouteTt  <= '0;
         portSpeedEff <= '0;
         portLedGreen <= '0;
         portLedAmber <= '0;
         portChange   <= '0;
         connPrev_reg <= '0;
         ovcPrev_reg  <= '0;
      end else begin
         connPrev_reg <= portConnect;
         ovcPrev_reg  <= portOvcDet;
         for (int i = 0; i < NPORT; i++) begin
            portChange[i] <= (portConnect[i] ^ connPrev_reg[i])
                             || (portOvcDet[i] && !ovcPrev_reg[i])
                             || (portWake[i] && !suspended);
            if (cfgNext == 8'h00 || portOvcDet[i]) begin
               portPower[i] <= 1'b0;
            end else if (portPowerSet[i]) begin
               portPower[i] <= 1'b1;
            end
            if (!portConnect[i]) begin
               portEnabled[i]  <= 1'b0;
               portRouteTt[i]  <= 1'b0;
               portSpeedEff[i] <= SPD_LS;
            end else if (portResetDone[i]) begin
               portEnabled[i]  <= 1'b1;
               portRouteTt[i]  <= uhr_route_tt(hostHs, portSpeed[i]);
               portSpeedEff[i] <= (!hostHs && portSpeed[i] == SPD_HS) ? SPD_FS
                                  : portSpeed[i];
            end
            portLedGreen[i] <= portEnabled[i] && !suspended;
            portLedAmber[i] <= portOvcDet[i] && !suspended;
         end
      end
   end

   // One translator shared by all ports; a busy translator drops new splits
   always_ff @(posedge clk) begin
      if (rst) begin
         ttStart <= 1'b0;
         ttPort  <= '0;
         ttBusy  <= 1'b0;
      end else begin
         ttStart <= 1'b0;
         if (ttBusy && ttDone) begin
            ttBusy <= 1'b0;
         end else if (splitValid && hostHs && configured && !ttBusy
                      && portRouteTt[splitPort]) begin
            ttStart <= 1'b1;
            ttPort  <= splitPort;
            ttBusy  <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_route_tt;
      portConnect[0] && portResetDone[0] && hostHs && portSpeed[0] != SPD_HS
      |=> portRouteTt[0];
   endproperty
   a_route_tt: assert property (p_route_tt) else $error("mismatch not via TT");

   property p_route_rep;
      portConnect[0] && portResetDone[0] && hostHs && portSpeed[0] == SPD_HS
      |=> !portRouteTt[0];
   endproperty
   a_route_rep: assert property (p_route_rep) else $error("match not via repeater");

   property p_fs_host;
      portConnect[1] && portResetDone[1] && !hostHs
      |=> !portRouteTt[1] && portSpeedEff[1] != SPD_HS;
   endproperty
   a_fs_host: assert property (p_fs_host) else $error("FS host speed limit");

   property p_split;
      splitValid && hostHs && configured && !ttBusy && portRouteTt[splitPort]
      |=> ttStart && ttBusy && ttPort == $past(splitPort);
   endproperty
   a_split: assert property (p_split) else $error("split not accepted");

   property p_boundary;
      rxActive_reg && !rxEop |=> $stable(dnPort);
   endproperty
   a_boundary: assert property (p_boundary) else $error("route changed in packet");

   property p_bus_reset;
      busReset |=> devAddr == 7'h00 && cfgValue == 8'h00 && !configured;
   endproperty
   a_bus_reset: assert property (p_bus_reset) else $error("bus reset state");

   property p_unconf_ports;
      !configured |-> portSe0 == 4'hF && portPower == 4'h0;
   endproperty
   a_unconf_ports: assert property (p_unconf_ports) else $error("port not held");

   sequence s_wake;
      suspended && !resumeOut && |portWake;
   endsequence
   sequence s_resume;
      resumeOut [*8];
   endsequence
   property p_wake;
      s_wake |=> s_resume;
   endproperty
   a_wake: assert property (p_wake) else $error("wake not propagated");

   property p_ee_adopt;
      eeState_reg == EE_CHECK && eeSum_reg != eeBuf[EE_LAST] && !idsFromEe
      |=> !idsFromEe && ids.vid == DEF_VID;
   endproperty
   a_ee_adopt: assert property (p_ee_adopt) else $error("bad image adopted");
endmodule : uhr_hub_core

`default_nettype wire

//--- tb/uhr_ee_model.sv
`timescale 1ns/1ps
`default_nettype none

module uhr_ee_model #(
   parameter logic [15:0] VID = 16'hBEEF,
   parameter logic [15:0] PID = 16'hCAFE
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       eeReq,
   input  wire logic [2:0] eeAddr,
   input  wire logic       badSum,
   output logic [7:0]      eeData,
   output logic            eeAck
);
   // Signature, identifiers, two filler bytes
   localparam logic [55:0] IMG = {8'h81, 8'h3C, PID, VID, 8'hA5};
   localparam logic [7:0]  SUM = 8'hA5 + VID[7:0] + VID[15:8] + PID[7:0] + PID[15:8] + 8'hBD;
   logic [1:0] waitCnt;

   always_ff @(posedge clk) begin
      eeAck <= 1'b0;
      if (rst) begin
         waitCnt <= 2'h0;
         eeData  <= 8'h5A;
      end else if (eeReq && !eeAck) begin
         // Odd bytes answered slowly, even ones at once
         if (waitCnt == {eeAddr[0], eeAddr[0]}) begin
            eeAck   <= 1'b1;
            waitCnt <= 2'h0;
            // Corrupted sum forces the fallback path
            eeData  <= (eeAddr == 3'h7) ? SUM + {7'h0, badSum} : IMG[eeAddr*8 +: 8];
         end else begin
            waitCnt <= waitCnt + 2'h1;
            eeData  <= ~eeData;
         end
      end else begin
         // Released bus toggles so stale bytes never pass
         eeData <= ~eeData;
      end
   end
endmodule : uhr_ee_model

`default_nettype wire

//--- tb/uhr_hub_core_tb.sv
`timescale 1ns/1ps
`default_nettype none

module uhr_hub_core_tb;
   import uhr_pkg::*;
   logic clk = 1'b0, dnReady = 1'b0, stall = 1'b1, badSum = 1'b1;
   logic rst, eePresent, eeAck, eeReq, idsFromEe, pullupEn, busReset, hostHs, setAddr, setCfg;
   logic configured, tokenValid, tokenHit, uframeTick, rxBit, rxBitValid, rxEop, rxBitReady;
   logic stuffErr, dnValid, busIdle, suspended, resumeOut, splitValid, ttDone, ttStart, ttBusy;
   logic [7:0] eeData, newCfg, cfgValue, dnData;
   logic [6:0] newAddr, devAddr;
   logic [3:0] tokenKind, portConnect, portOvcDet, portPowerSet, portResetDone, portWake;
   logic [3:0] portPower, portSe0, portEnabled, portRouteTt, portLedGreen, portLedAmber;
   logic [3:0] portChange;
   logic [3:0][1:0] portSpeed, portSpeedEff;
   logic [2:0] eeAddr;
   logic [1:0] txTarget, dnPort, splitPort, ttPort, s;
   uhr_ids_s ids;
   uhr_token_s token;
   logic [7:0] expQ [$];
   int n_fail = 0, comparisons = 0, i;

   uhr_hub_core #(.SUSP_CYCLES(20), .RESUME_CYCLES(10), .UFRAME_CYCLES(50)) uhr_hub_core_i (.*);
   uhr_ee_model uhr_ee_model_i (.*);

   always #2.5 clk = ~clk;
   always @(posedge clk) dnReady <= stall ? 1'b0 : 1'($urandom_range(1, 0));

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask : chk

   task automatic limit(input int n);
      if (i >= n) begin
         n_fail++;
         $display("ERROR %0t wait ran out", $time);
         give_verdict();
      end
   endtask : limit

   task automatic enumer(input logic [6:0] a);
      @(posedge clk) {setAddr, newAddr} <= {1'b1, a};
      @(posedge clk) {setAddr, setCfg, newCfg} <= {2'b01, 8'h01};
      @(posedge clk) setCfg <= 1'b0;
      @(negedge clk);
      chk(devAddr, a, "address");
      chk({configured, cfgValue, portSe0}, 13'h1010, "configured");
   endtask : enumer

   task automatic split(input logic [1:0] p, input logic ok);
      @(posedge clk) {splitValid, splitPort} <= {1'b1, p};
      @(posedge clk) splitValid <= 1'b0;
      for (i = 0; i < 3 && ttStart !== 1'b1; i++) @(negedge clk);
      chk(ttStart, ok, "split start");
      if (ok) begin
         chk({ttPort, ttBusy}, {p, 1'b1}, "split port");
         @(posedge clk) ttDone <= 1'b1;
         @(posedge clk) ttDone <= 1'b0;
         repeat (2) @(negedge clk);
         chk(ttBusy, 1'b0, "translator freed");
      end
   endtask : split

   // Token with address and endpoint zero; crc 5'h02 is the good check for that
   task automatic tok(input logic [7:0] pd, input logic [4:0] c, input logic hit);
      @(posedge clk) {tokenValid, token} <= {1'b1, pd, 7'h00, 4'h0, c};
      @(posedge clk) tokenValid <= 1'b0;
      @(negedge clk);
      chk({tokenHit, tokenKind}, {hit, pd[3:0]}, "token");
      if (pd[3:0] == PID_SOF) chk(uframeTick, 1'b1, "frame tick");
   endtask : tok

   // Bits go out LSB first; each is held until the edge that takes it
   task automatic sendByte(input logic [7:0] b);
      expQ.push_back(b);
      for (int k = 0; k < 8; k++) begin
         @(posedge clk) {rxBit, rxBitValid} <= {b[k], 1'b1};
         for (i = 0; i < 400; i++) begin
            @(negedge clk);
            if (rxBitReady === 1'b1) break;
         end
         limit(400);
      end
      @(posedge clk) rxBitValid <= 1'b0;
   endtask : sendByte

   // Falling edge shows the handshake of the next rising edge
   always @(negedge clk) begin
      if (rst === 1'b0 && dnValid === 1'b1 && dnReady === 1'b1) begin
         if (expQ.size() == 0) chk(32'h1, 32'h0, "byte not sent");
         else chk(dnData, expQ.pop_front(), "stream byte");
      end
   end

   initial begin
      void'($urandom(32'hF8FA4C3A));
      {rst, eePresent, busReset, hostHs, setAddr, setCfg, tokenValid} = 7'h60;
      {rxBit, rxBitValid, rxEop, busIdle, splitValid, ttDone, newCfg, newAddr} = '0;
      {portConnect, portOvcDet, portPowerSet, portResetDone, portWake, portSpeed} = '0;
      {txTarget, splitPort, token} = '0;
      for (int r = 0; r < 2; r++) begin
         @(posedge clk) badSum <= (r == 0);
         rst <= 1'b1;
         repeat (20) @(posedge clk);
         rst <= 1'b0;
         @(posedge clk) {setCfg, newCfg} <= {1'b1, 8'h01};
         @(posedge clk) setCfg <= 1'b0;
         for (i = 0; i < 400 && pullupEn !== 1'b1; i++) @(negedge clk);
         limit(400);
         chk(cfgValue, 8'h00, "config before pull-up");
         chk(idsFromEe, r, "image source");
         chk(ids, r ? 32'hBEEFCAFE : {DEF_VID, DEF_PID}, "identifiers");
      end
      enumer(7'h05);
      // Host resets the bus after the pull-up
      @(posedge clk) busReset <= 1'b1;
      repeat (3) @(posedge clk);
      busReset <= 1'b0;
      @(negedge clk);
      chk({devAddr, cfgValue, configured, portSe0}, 20'hF, "bus reset");
      chk(portPower, 4'h0, "power off unconfigured");
      tok(8'h2D, 5'h02, 1'b1);
      tok(8'h2D, 5'h03, 1'b0);
      tok(8'hA5, 5'h02, 1'b0);
      enumer(7'($urandom_range(127, 1)));
      @(posedge clk) portPowerSet <= 4'hF;
      @(posedge clk) portPowerSet <= 4'h0;
      repeat (2) @(negedge clk);
      chk(portPower, 4'hF, "port power");
      for (int h = 1; h >= 0; h--) begin
         @(posedge clk) hostHs <= h[0];
         for (int p = 0; p < 4; p++) begin
            s = 2'(p % 3);
            @(posedge clk) {portSpeed[p], portConnect[p], portResetDone[p]} <= {s, 2'b11};
            @(posedge clk) portResetDone[p] <= 1'b0;
            repeat (2) @(negedge clk);
            chk(portRouteTt[p], h && s != SPD_HS, "route");
            chk(portSpeedEff[p], (!h && s == SPD_HS) ? SPD_FS : s, "speed");
         end
         @(posedge clk) portSpeed <= '0;
         repeat (2) @(negedge clk);
         chk({portEnabled, portRouteTt}, h ? 8'hFB : 8'hF0, "route held");
         if (h) begin
            split(2'h2, 1'b0);
            split(2'h0, 1'b1);
         end
         @(posedge clk) portConnect <= 4'h0;
         repeat (2) @(negedge clk);
         chk({portEnabled, portRouteTt}, 8'h00, "disconnect");
         chk(portChange, 4'hF, "disconnect change");
      end
      // Buffer filled while the far side stalls
      @(posedge clk) txTarget <= 2'h2;
      for (int b = 0; b < 16; b++) sendByte(8'($urandom) & 8'h77);
      fork
         for (int b = 0; b < 6; b++) sendByte(8'($urandom) & 8'h77);
         begin
            repeat (200) @(negedge clk);
            chk(rxBitReady, 1'b0, "full buffer refuses");
            // Target moves mid-packet; route must not follow
            @(posedge clk) {stall, txTarget} <= {1'b0, 2'h1};
         end
      join
      for (i = 0; i < 3000 && expQ.size() > 0; i++) @(negedge clk);
      limit(3000);
      chk(dnPort, 2'h2, "route held in packet");
      @(posedge clk) rxEop <= 1'b1;
      @(posedge clk) {rxEop, busIdle} <= 2'b01;
      for (i = 0; i < 100 && suspended !== 1'b1; i++) @(negedge clk);
      limit(100);
      chk({portLedGreen, portLedAmber}, 8'h00, "leds off in suspend");
      @(posedge clk) portWake <= 4'h1;
      @(posedge clk) portWake <= 4'h0;
      for (i = 0; i < 5 && resumeOut !== 1'b1; i++) @(negedge clk);
      limit(5);
      @(posedge clk) busIdle <= 1'b0;
      repeat (3) @(negedge clk);
      chk(suspended, 1'b0, "suspend left");
      give_verdict();
   end
endmodule : uhr_hub_core_tb

`default_nettype wire
